// ---- pgs_glue.sv ----
// Power glue sequencer: main power good, backfeed cut, supply on, LED.
//
// Functional notes
// R1 - Main power good drops on sleep or supply loss.
// R2 - Main power good rises after fixed delay.
// R3 - Backfeed cut low when supply good, awake.
// R4 - Backfeed rising edge sets held cut, S5 high.
// R5 - Backfeed falling edge clears held cut, S5 high.
// R6 - Held cut stays low while S5 low.
// R7 - Supply on only with processor, awake, no trip.
// R8 - After trip, supply off until S3 rises.
// R9 - Disk LED on when any drive active.
// R10 - Isolate SMBus segments while supply power bad.
// R11 - Inputs synchronised; delay is restartable counter.
// R12 - Reset clears memories, outputs to safe levels.
`timescale 1ns/1ps

module pgs_glue #(
	parameter int unsigned PG_DELAY_CYCLES = pgs_pkg::POWER_GOOD_DELAY_CYC
) (
	input  wire logic ref_clk_in,                     // System clock.
	input  wire logic reset_in,                       // Sync reset, high.
	input  wire logic supply_power_good_in,           // Supply good, high.
	input  wire logic sleep_s3_n_in,                  // S3 sleep, low.
	input  wire logic sleep_s5_n_in,                  // S5 sleep, low.
	input  wire logic processor_inserted_n_in,        // Processor_inserted_n, low.
	input  wire logic thermal_trip_condition_in,      // Trip present, high.
	input  wire logic first_disk_activity_n_in,       // Drive 1 busy, low.
	input  wire logic second_disk_activity_n_in,      // Drive 2 busy, low.
	input  wire logic small_computer_disk_activity_n_in, // Drive 3, low.
	output logic      main_power_good_out,            // Main power valid.
	output logic      backfeed_cut_n_out,             // Backfeed cut, low.
	output logic      held_backfeed_cut_out,          // Latched cut.
	output logic      supply_on_n_out,                // Supply on, low.
	output logic      disk_led_n_out,                 // Disk LED, low.
	output logic      smbus_isolate_out               // Force switches open.
);

	// ======================================================================
	// Types and state
	// ======================================================================

	// Power-good sequence: supply bad, delay running, delay elapsed.
	typedef enum logic [1:0] {
		PG_OFF,
		PG_WAIT,
		PG_DONE
	} pgs_pg_e;

	// All state of the sequencer in one record.
	typedef struct packed {
		pgs_pg_e                       pg_state;  // Delay sequence.
		logic [pgs_pkg::PG_CNT_W-1:0]  pg_cnt;    // Delay counter.
		logic                          s3_prev;   // S3 for edge detect.
		logic                          trip_mem;  // Trip has occurred.
		logic                          main_pg;   // Main power good.
		logic                          bkfd_n;    // Backfeed cut, low.
		logic                          held;      // Latched cut.
		logic                          supply_n;  // Supply on, low.
		logic                          led_n;     // Disk LED, low.
		logic                          isolate;   // SMBus isolation.
	} pgs_state_s;

	pgs_state_s st;      // Registered state.
	pgs_state_s next_st; // Next state.

	// Last counter value before the delay counts as elapsed.
	localparam logic [pgs_pkg::PG_CNT_W-1:0] PG_LAST =
		pgs_pkg::PG_CNT_W'(PG_DELAY_CYCLES - 1);

	// ======================================================================
	// Input synchronisation
	// ======================================================================

	logic [pgs_pkg::SYNC_W-1:0] raw;   // Pin levels gathered.
	logic [pgs_pkg::SYNC_W-1:0] clean; // Synchronised levels.

	// Gather the pins so one synchroniser instance serves them all.
	assign raw = {small_computer_disk_activity_n_in,
		second_disk_activity_n_in,
		first_disk_activity_n_in,
		thermal_trip_condition_in,
		processor_inserted_n_in,
		sleep_s5_n_in,
		sleep_s3_n_in,
		supply_power_good_in};

	// Every asynchronous input passes four flops: three stages and the agreement register.
	pgs_sync u_sync ( // R11
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.raw_in     (raw),
		.clean_out  (clean)
	);

	logic pg;      // Supply good, synchronised.
	logic s3_n;    // S3 sleep, synchronised.
	logic s5_n;    // S5 sleep, synchronised.
	logic cpu_n;   // Processor present, synchronised.
	logic trip;    // Thermal trip, synchronised.
	logic disk_any; // Any drive active.

	assign pg    = clean[pgs_pkg::IDX_SUPPLY_PG];
	assign s3_n  = clean[pgs_pkg::IDX_SLEEP_S3];
	assign s5_n  = clean[pgs_pkg::IDX_SLEEP_S5];
	assign cpu_n = clean[pgs_pkg::IDX_CPU_IN];
	assign trip  = clean[pgs_pkg::IDX_THERMAL];
	assign disk_any = ~(clean[pgs_pkg::IDX_DISK_FIRST] &
		clean[pgs_pkg::IDX_DISK_SECOND] &
		clean[pgs_pkg::IDX_DISK_SMALL]);

	// ======================================================================
	// Next-state logic
	// ======================================================================

	// All outputs are computed here from the synchronised levels and
	// registered once, so each output follows its cause by one cycle, except
	// supply on, which follows an S3 rise after a trip by two cycles.
	always_comb begin
		next_st         = st;
		next_st.s3_prev = s3_n;

		// Delay sequence: a supply rising edge restarts the counter,
		// and any supply loss abandons it at once.
		case (st.pg_state)
			PG_OFF: begin
				if (pg) begin
					next_st.pg_state = PG_WAIT; // R11
					next_st.pg_cnt   = '0;
				end
			end
			PG_WAIT: begin
				if (!pg) begin
					next_st.pg_state = PG_OFF;
				end else if (st.pg_cnt >= PG_LAST) begin
					next_st.pg_state = PG_DONE; // R2
				end else begin
					next_st.pg_cnt = st.pg_cnt + 1'b1;
				end
			end
			PG_DONE: begin
				if (!pg) begin
					next_st.pg_state = PG_OFF;
				end
			end
			default: begin
				next_st.pg_state = PG_OFF;
			end
		endcase

		// Sleep entry masks power good without restarting the delay.
		next_st.main_pg = (next_st.pg_state == PG_DONE) && pg && s3_n; // R1

		// Backfeed cut is active whenever the supply is good and awake.
		next_st.bkfd_n = ~(pg & s3_n); // R3

		// Latched cut follows edges of the cut output, but S5 wins.
		if (!s5_n) begin
			next_st.held = 1'b0; // R6
		end else if (next_st.bkfd_n && !st.bkfd_n) begin
			next_st.held = 1'b1; // R4
		end else if (!next_st.bkfd_n && st.bkfd_n) begin
			next_st.held = 1'b0; // R5
		end

		// Trip memory: a trip present in the same cycle as the S3 rise
		// sets the memory again, so the set wins over the clear.
		if (trip) begin
			next_st.trip_mem = 1'b1;
		end else if (s3_n && !st.s3_prev) begin
			next_st.trip_mem = 1'b0; // R8
		end

		// Supply on needs the processor, wake state and no trip, live
		// or remembered.
		next_st.supply_n = ~(!cpu_n && s3_n && !trip && !st.trip_mem); // R7

		// Any active drive lights the LED.
		next_st.led_n = ~disk_any; // R9

		// Segments are kept apart while the supply is not valid.
		next_st.isolate = ~pg; // R10
	end

	// ======================================================================
	// State register
	// ======================================================================

	// Reset puts every output at its safe level and forgets any trip.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			st.pg_state <= PG_OFF;
			st.pg_cnt   <= '0;
			st.s3_prev  <= 1'b0;
			st.trip_mem <= 1'b0; // R12
			st.main_pg  <= pgs_pkg::MAIN_PG_RESET;
			st.bkfd_n   <= pgs_pkg::BKFD_N_RESET;
			st.held     <= pgs_pkg::HELD_RESET;
			st.supply_n <= pgs_pkg::SUPPLY_N_RESET;
			st.led_n    <= pgs_pkg::LED_N_RESET;
			st.isolate  <= pgs_pkg::ISOLATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from flops.
	assign main_power_good_out   = st.main_pg;
	assign backfeed_cut_n_out    = st.bkfd_n;
	assign held_backfeed_cut_out = st.held;
	assign supply_on_n_out       = st.supply_n;
	assign disk_led_n_out        = st.led_n;
	assign smbus_isolate_out     = st.isolate;

	// ======================================================================
	// Assertions
	// ======================================================================

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	// Cycles for which the synchronised supply has been good in a row.
	logic [pgs_pkg::PG_CNT_W:0] chk_pg_run; // Saturating run counter.

	// Helper counter; saturates well above the delay.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || !pg) begin
			chk_pg_run <= '0;
		end else if (!chk_pg_run[pgs_pkg::PG_CNT_W]) begin
			chk_pg_run <= chk_pg_run + 1'b1;
		end
	end

	a_pg_drop_now: assert property ( // R1
		(!s3_n || !pg) |=> !main_power_good_out)
		else $error("main power good not dropped");

	// The run counter starts one edge before the delay counter, so a
	// correct rise always sees more than the full delay behind it.
	a_pg_after_delay: assert property ( // R2
		$rose(main_power_good_out) |->
			(chk_pg_run > (pgs_pkg::PG_CNT_W + 1)'(PG_DELAY_CYCLES)))
		else $error("main power good rose too early");

	a_bkfd_level: assert property ( // R3
		##1 (backfeed_cut_n_out == !($past(pg) && $past(s3_n))))
		else $error("backfeed cut level wrong");

	a_held_set: assert property ( // R4
		($rose(backfeed_cut_n_out) && $past(s5_n)) |->
			held_backfeed_cut_out)
		else $error("held cut not set on rising edge");

	a_held_clear: assert property ( // R5
		$fell(backfeed_cut_n_out) |-> !held_backfeed_cut_out)
		else $error("held cut not cleared on falling edge");

	a_held_s5_low: assert property ( // R6
		!s5_n |=> !held_backfeed_cut_out)
		else $error("held cut high during S5");

	// The request is registered, so it is judged against the levels
	// that were sampled one edge earlier.
	a_supply_on_cond: assert property ( // R7
		!supply_on_n_out |->
			(!$past(cpu_n) && $past(s3_n) && !$past(trip)))
		else $error("supply on without its conditions");

	// Two quiet cycles after a trip must leave the supply off, since
	// only an S3 rise may clear the remembered trip.
	a_trip_hold: assert property ( // R8
		(trip ##1 (!$rose(s3_n))[*2]) |=> supply_on_n_out)
		else $error("supply on after trip without S3 rise");

	a_disk_led: assert property ( // R9
		disk_any |=> !disk_led_n_out)
		else $error("disk LED off while drive active");

	a_smbus_isolate: assert property ( // R10
		!pg |=> smbus_isolate_out)
		else $error("segments not isolated while supply bad");

	// Reset is the very condition checked here, so the default disable
	// is switched off for this one property; with it the check would
	// never be evaluated at all.
	a_reset_safe: assert property ( // R12
		@(posedge ref_clk_in) disable iff (1'b0) reset_in |=>
			(!main_power_good_out && supply_on_n_out &&
			!held_backfeed_cut_out))
		else $error("outputs not safe after reset");

	c_pg_rise: cover property ($rose(main_power_good_out));
	c_held_set: cover property ($rose(held_backfeed_cut_out));
	c_trip_recover: cover property (
		$rose(st.trip_mem) ##[1:1000] $fell(st.trip_mem));
	c_supply_on: cover property ($fell(supply_on_n_out));

endmodule

// ---- pgs_supply_model.sv ----
// Behavioural main power supply that answers the glue's supply-on request.
`timescale 1ns/1ps

// ==========================================================================
// Main power supply model
// ==========================================================================
module pgs_supply_model #(
	parameter int unsigned RISE_CYCLES = 8 // Ramp time to power good.
) (
	input  wire logic ref_clk_in,           // System clock.
	input  wire logic supply_on_n_in,       // Turn-on request, low.
	input  wire logic fault_in,             // Forced supply failure.
	output logic      supply_power_good_out // Output voltage valid.
);
	int unsigned ramp = 0; // Cycles spent ramping since the request.

	// The ramp counts on the rising edge, so it reads the fault pin only
	// after the bench has settled it on the falling edge; counting on the
	// same edge as the bench would race with it.
	// A real supply needs time to ramp, so power good lags the request;
	// a long ramp lets the bench see the glue wait on a slow supply.
	always @(posedge ref_clk_in) begin
		if (supply_on_n_in !== 1'b0 || fault_in) begin
			ramp <= 0;
		end else if (ramp < RISE_CYCLES) begin
			ramp <= ramp + 1;
		end
	end

	// Losing the request or a fault drops power good at once, no lag.
	assign supply_power_good_out = (supply_on_n_in === 1'b0) && !fault_in
		&& (ramp >= RISE_CYCLES);
endmodule

// ---- pgs_sync.sv ----
// Shared constants and the three-stage input synchroniser of the power glue.
`timescale 1ns/1ps

// ==========================================================================
// Shared constants
// ==========================================================================
package pgs_pkg;

	// Number of asynchronous level inputs that pass the synchroniser.
	localparam int unsigned SYNC_W = 8;

	// Bit positions of each input inside the synchronised vector.
	localparam int unsigned IDX_SUPPLY_PG   = 0;
	localparam int unsigned IDX_SLEEP_S3    = 1;
	localparam int unsigned IDX_SLEEP_S5    = 2;
	localparam int unsigned IDX_CPU_IN      = 3;
	localparam int unsigned IDX_THERMAL     = 4;
	localparam int unsigned IDX_DISK_FIRST  = 5;
	localparam int unsigned IDX_DISK_SECOND = 6;
	localparam int unsigned IDX_DISK_SMALL  = 7;

	// Reset value of the vector: supply bad, sleeping, no processor,
	// no trip and every drive idle, so no edge is faked at release.
	localparam logic [SYNC_W-1:0] SYNC_RESET = 8'he8;

	// Clock period and the power-good assertion delay, both in ns.
	localparam int unsigned CLK_PERIOD_NS        = 4;
	localparam int unsigned POWER_GOOD_DELAY_NS  = 1000000;

	// Least delay, so the cycle count rounds up.
	localparam int unsigned POWER_GOOD_DELAY_CYC =
		(POWER_GOOD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Width of the delay counter.
	localparam int unsigned PG_CNT_W = 24;

	// Reset values of the outputs.
	localparam logic MAIN_PG_RESET  = 1'b0;
	localparam logic BKFD_N_RESET   = 1'b1;
	localparam logic HELD_RESET     = 1'b0;
	localparam logic SUPPLY_N_RESET = 1'b1;
	localparam logic LED_N_RESET    = 1'b1;
	localparam logic ISOLATE_RESET  = 1'b1;

endpackage

// ==========================================================================
// Three-flop synchroniser with agreement filter
// ==========================================================================
module pgs_sync (
	input  wire logic                      ref_clk_in, // System clock.
	input  wire logic                      reset_in,   // Sync reset, high.
	input  wire logic [pgs_pkg::SYNC_W-1:0] raw_in,    // Pin levels.
	output logic      [pgs_pkg::SYNC_W-1:0] clean_out  // Accepted levels.
);

	// All state of the synchroniser in one record.
	typedef struct packed {
		logic [pgs_pkg::SYNC_W-1:0] stage1; // Metastable catch stage.
		logic [pgs_pkg::SYNC_W-1:0] stage2; // Second stage.
		logic [pgs_pkg::SYNC_W-1:0] stage3; // Third stage.
		logic [pgs_pkg::SYNC_W-1:0] clean;  // Accepted level.
	} pgs_sync_s;

	pgs_sync_s st;      // Registered state.
	pgs_sync_s next_st; // Next state.

	// A level is accepted only once stages two and three agree, so a
	// one-cycle glitch that slips past the first flop is never passed on.
	// Stage one feeds only stage two.
	always_comb begin
		next_st        = st;
		next_st.stage1 = raw_in;
		next_st.stage2 = st.stage1;
		next_st.stage3 = st.stage2;
		for (int i = 0; i < pgs_pkg::SYNC_W; i++) begin
			if (st.stage2[i] == st.stage3[i]) begin
				next_st.clean[i] = st.stage3[i];
			end
		end
	end

	// State register with synchronous reset to constants.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			st <= '{pgs_pkg::SYNC_RESET, pgs_pkg::SYNC_RESET,
				pgs_pkg::SYNC_RESET, pgs_pkg::SYNC_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign clean_out = st.clean;

endmodule

// ---- testbench.sv ----
// Self-checking testbench of the power glue sequencer.
`timescale 1ns/1ps

// ==========================================================================
// Testbench top
// ==========================================================================
module testbench;
	localparam int unsigned PG     = 20;   // Shortened power-good delay.
	localparam int unsigned LIMIT  = 5000; // Cycle ceiling of the run.

	logic ref_clk_in, reset_in, pg, s3_n, s5_n, cpu_n, trip, fault;
	logic d1_n, d2_n, d3_n;                // Drive activity pins.
	logic main_pg, bkfd_n, held, on_n, led_n, iso; // Design outputs.
	int   errors = 0;                      // Mismatches seen.
	int   checks_done = 0;                 // Comparisons made.
	int   cycles = 0;                      // Clock cycles elapsed.

	pgs_glue #(.PG_DELAY_CYCLES(PG)) i_pgs_glue (
		.ref_clk_in                        (ref_clk_in),
		.reset_in                          (reset_in),
		.supply_power_good_in              (pg),
		.sleep_s3_n_in                     (s3_n),
		.sleep_s5_n_in                     (s5_n),
		.processor_inserted_n_in           (cpu_n),
		.thermal_trip_condition_in         (trip),
		.first_disk_activity_n_in          (d1_n),
		.second_disk_activity_n_in         (d2_n),
		.small_computer_disk_activity_n_in (d3_n),
		.main_power_good_out               (main_pg),
		.backfeed_cut_n_out                (bkfd_n),
		.held_backfeed_cut_out             (held),
		.supply_on_n_out                   (on_n),
		.disk_led_n_out                    (led_n),
		.smbus_isolate_out                 (iso)
	);

	pgs_supply_model #(.RISE_CYCLES(8)) i_pgs_supply_model (
		.ref_clk_in            (ref_clk_in),
		.supply_on_n_in        (on_n),
		.fault_in              (fault),
		.supply_power_good_out (pg)
	);

	// Free-running 250 MHz clock.
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	// ======================================================================
	// Shared tasks
	// ======================================================================
	// Waits whole cycles; the bench always resumes on a falling edge.
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask

	// Compares one seen bit with its expected value and counts the result.
	task automatic check(input string name, input logic seen, input logic exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %b seen %b", name, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// A hang is cut short here and counted as a mismatch.
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			summarize();
		end
	end

	// ======================================================================
	// Scenarios
	// ======================================================================
	// Power up from sleep and time main power good against the delay.
	task automatic test_power_up();
		int n;
		n = 0;
		cpu_n = 1'b0;
		s5_n  = 1'b1;
		s3_n  = 1'b1;
		wait_cyc(7);
		check("supply_on_n", on_n, 1'b0);
		while (pg !== 1'b1 && n < 100) begin
			wait_cyc(1);
			n++;
		end
		n = 0;
		while (main_pg !== 1'b1 && n < PG + 40) begin
			wait_cyc(1);
			n++;
		end
		check("pg_not_early", n >= PG, 1'b1);
		check("pg_not_late", n <= PG + 8, 1'b1);
		check("backfeed_n", bkfd_n, 1'b0);
		check("isolate", iso, 1'b0);
		check("held_cut", held, 1'b0);
	endtask

	// Sleep entry and exit move the backfeed cut and its latched copy.
	task automatic test_held_cut();
		s3_n = 1'b0;
		wait_cyc(7);
		check("main_pg_s3", main_pg, 1'b0);
		check("backfeed_n_s3", bkfd_n, 1'b1);
		check("held_set", held, 1'b1);
		check("supply_off_s3", on_n, 1'b1);
		s5_n = 1'b0;
		wait_cyc(7);
		check("held_s5", held, 1'b0);
		s3_n = 1'b1;
		wait_cyc(30);
		check("backfeed_n_up", bkfd_n, 1'b0);
		check("held_s5_fall", held, 1'b0);
		s5_n = 1'b1;
		s3_n = 1'b0;
		wait_cyc(7);
		check("held_set2", held, 1'b1);
		s3_n = 1'b1;
		wait_cyc(30);
		check("held_clear", held, 1'b0);
		wait_cyc(PG + 10);
		check("main_pg_back", main_pg, 1'b1);
	endtask

	// A supply failure drops power good and isolates the bus within seven cycles.
	task automatic test_fault();
		fault = 1'b1;
		wait_cyc(7);
		check("main_pg_fault", main_pg, 1'b0);
		check("backfeed_n_fault", bkfd_n, 1'b1);
		check("isolate_fault", iso, 1'b1);
		fault = 1'b0;
		wait_cyc(PG + 25);
		check("main_pg_after", main_pg, 1'b1);
		check("isolate_after", iso, 1'b0);
	endtask

	// A trip keeps the supply off until sleep is passed through.
	task automatic test_trip();
		trip = 1'b1;
		wait_cyc(7);
		check("supply_trip", on_n, 1'b1);
		trip = 1'b0;
		wait_cyc(20);
		check("supply_trip_hold", on_n, 1'b1);
		s3_n = 1'b0;
		wait_cyc(7);
		s3_n = 1'b1;
		wait_cyc(7);
		check("supply_rearm", on_n, 1'b0);
		cpu_n = 1'b1;
		wait_cyc(7);
		check("supply_no_cpu", on_n, 1'b1);
		cpu_n = 1'b0;
		wait_cyc(7);
		check("supply_cpu", on_n, 1'b0);
	endtask

	// Every combination of the three drive pins against the LED.
	task automatic test_led();
		for (int i = 0; i < 8; i++) begin
			{d3_n, d2_n, d1_n} = i[2:0];
			wait_cyc(7);
			check("disk_led_n", led_n, &i[2:0]);
		end
	endtask

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		reset_in = 1'b1;
		s3_n  = 1'b0;
		s5_n  = 1'b0;
		cpu_n = 1'b1;
		trip  = 1'b0;
		fault = 1'b0;
		d1_n  = 1'b1;
		d2_n  = 1'b1;
		d3_n  = 1'b1;
		wait_cyc(20);
		check("rst_main_pg", main_pg, 1'b0);
		check("rst_held", held, 1'b0);
		check("rst_supply_n", on_n, 1'b1);
		check("rst_backfeed_n", bkfd_n, 1'b1);
		reset_in = 1'b0;
		test_power_up();
		test_held_cut();
		test_fault();
		test_trip();
		test_led();
		summarize();
	end
endmodule
